// ---- spm_consts.vh ----
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH
`define SPM_OP_PREFIX0 8'h3d
`define SPM_OP_PREFIX1 8'h2a
`define SPM_OP_PREFIX2 8'h7f
`define SPM_OP_ERASE 8'hcf
`define SPM_OP_PROGRAM 8'hfc
`define SPM_OP_READ 8'h32
`define SPM_BYTE_PROT 8'hff
`define SPM_BYTE_UNPROT 8'h00
`define SPM_FACTORY_LOW_BYTES 8
`define SPM_READ_HDR_BYTES 4
`define SPM_CMD_BYTES 4
`define SPM_SUB_A_HI 7
`define SPM_SUB_A_LO 6
`define SPM_SUB_B_HI 5
`define SPM_SUB_B_LO 4
`define SPM_ERASE_TIME_NS 32'd20000
`define SPM_PROG_TIME_NS 32'd10000
`define SPM_CLK_NS 32'd10
`endif

// ---- spm_map_mem.v ----
module spm_map_mem #(
	parameter AW = 4,
	parameter DW = 8
) (
	input wire clock_in,
	input wire wr_en_in,
	input wire [AW-1:0] wr_addr_in,
	input wire [DW-1:0] wr_data_in,
	input wire [AW-1:0] rd_addr_in,
	output reg [DW-1:0] rd_data_out
);
	// working buffer one; contents simply overwritten, no reset needed
	reg [DW-1:0] mem [0:(1<<AW)-1];
	always @(posedge clock_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule

// ---- spm_map_cmd.v ----
// How it works
// [RL1] sixteen byte nonvolatile map, one per sector
// [RL2] sectors 1-15: ffh protected, 00h unprotected
// [RL3] byte 0: bits 7:6 and 5:4 subsectors
// [RL4] factory state: bytes 0-7 hold 00h
// [RL5] host erases map before programming it
// [RL6] erase opcode sequence starts erase on deselect
// [RL7] busy reported during map erase
// [RL8] erase accepted regardless of protection enable, sets all bytes ffh
// [RL9] erased map with protection blocks array writes
// [RL10] program sequence plus sixteen bytes, then deselect
// [RL11] busy reported during map program
// [RL12] data index wraps after sixteen bytes
// [RL13] host sends all sixteen bytes
// [RL14] host writes only valid codes
// [RL15] program accepted regardless of protection enable
// [RL16] program uses data buffer 1
// [RL17] read: 32h, three dummies, then bytes out
// [RL18] host ignores data past sixteenth byte
// [RL19] deselect releases serial output
// [RL20] host limits map modifications
// [RL21] write-protect asserted blocks map erase/program
// [RL22] msb first, sample on rising clock
// [RL23] commands ignored while busy; the read command is not gated by busy and is served
`include "spm_consts.vh"
module spm_map_cmd #(
	parameter NSECT = 16,
	parameter AW = 4,
	parameter ERASE_CYC = `SPM_ERASE_TIME_NS / `SPM_CLK_NS,
	parameter PROG_CYC = `SPM_PROG_TIME_NS / `SPM_CLK_NS
) (
	input wire clock_in,
	input wire rst_in,
	input wire cs_n_in,
	input wire sck_in,
	input wire si_in,
	input wire wp_n_in,
	input wire prot_en_in,
	input wire [AW-1:0] sector_in,
	input wire subsector_b_in,
	output reg so_out,
	output reg so_oe_n_out,
	output wire ready_out,
	output wire sector_protected_out,
	output wire array_write_ok_out,
	output reg buf1_wr_out,
	output reg [AW-1:0] buf1_addr_out,
	output reg [7:0] buf1_data_out
);
	localparam ST_CMD = 3'h0;
	localparam ST_PDATA = 3'h1;
	localparam ST_RDUMMY = 3'h2;
	localparam ST_ROUT = 3'h3;
	localparam ST_IGNORE = 3'h4;
	localparam OP_NONE = 2'h0;
	localparam OP_ERASE = 2'h1;
	localparam OP_PROG = 2'h2;

	// synchronise pins; only the second stage is read
	reg [1:0] cs_s_r;
	reg [1:0] sck_s_r;
	reg [1:0] si_s_r;
	reg [1:0] wp_s_r;
	reg sck_d_r;
	always @(posedge clock_in) begin
		if (rst_in) begin
			cs_s_r <= 2'h3;
			sck_s_r <= 2'h0;
			si_s_r <= 2'h0;
			wp_s_r <= 2'h3;
			sck_d_r <= 1'b0;
		end else begin
			cs_s_r <= {cs_s_r[0], cs_n_in};
			sck_s_r <= {sck_s_r[0], sck_in};
			si_s_r <= {si_s_r[0], si_in};
			wp_s_r <= {wp_s_r[0], wp_n_in};
			sck_d_r <= sck_s_r[1];
		end
	end
	wire cs_n = cs_s_r[1];
	wire wp_n = wp_s_r[1];
	wire sck_rise = sck_s_r[1] & ~sck_d_r;
	wire sck_fall = ~sck_s_r[1] & sck_d_r;
	reg cs_d_r;
	always @(posedge clock_in) begin
		if (rst_in) begin
			cs_d_r <= 1'b1;
		end else begin
			cs_d_r <= cs_n;
		end
	end
	wire cs_rise = cs_n & ~cs_d_r;

	// map storage, reset only models power-up factory contents
	// [RL1] one byte per sector
	reg [7:0] map_r [0:NSECT-1];
	reg [2:0] state_r;
	reg [2:0] bit_r;
	reg [7:0] sh_r;
	reg [2:0] hdr_r;
	reg [AW-1:0] idx_r;
	reg [1:0] pend_r;
	reg [1:0] run_r;
	reg [31:0] tmr_r;
	reg [7:0] out_sh_r;
	reg [7:0] b0_r;
	reg [7:0] b1_r;
	reg [7:0] b2_r;
	reg [AW-1:0] commit_idx_r;
	reg busy_commit_done_r;
	reg commit_start_r;
	// [RL7] [RL11] busy while cycling
	wire busy = (run_r != OP_NONE);
	assign ready_out = ~busy;
	wire [7:0] byte_in = {sh_r[6:0], si_s_r[1]};
	wire byte_done = sck_rise & (bit_r == 3'h7);
	wire [7:0] rd_byte;

	// prefix decode of the first three bytes
	wire pfx_ok = (b0_r == `SPM_OP_PREFIX0) & (b1_r == `SPM_OP_PREFIX1) &
		(b2_r == `SPM_OP_PREFIX2);

	integer i;
	always @(posedge clock_in) begin
		if (rst_in) begin
			state_r <= ST_CMD;
			bit_r <= 3'h0;
			sh_r <= 8'h00;
			hdr_r <= 3'h0;
			idx_r <= {AW{1'b0}};
			pend_r <= OP_NONE;
			run_r <= OP_NONE;
			tmr_r <= 32'h0;
			b0_r <= 8'h00;
			b1_r <= 8'h00;
			b2_r <= 8'h00;
			buf1_wr_out <= 1'b0;
			buf1_addr_out <= {AW{1'b0}};
			buf1_data_out <= 8'h00;
			// [RL4] factory low bytes unprotected
			for (i = 0; i < NSECT; i = i + 1) begin
				map_r[i] <= (i < `SPM_FACTORY_LOW_BYTES) ? `SPM_BYTE_UNPROT :
					`SPM_BYTE_PROT;
			end
		end else begin
			buf1_wr_out <= 1'b0;
			// self-timed cycles; busy shown while running
			if (busy) begin
				if (tmr_r <= 32'h1) begin
					run_r <= OP_NONE;
					tmr_r <= 32'h0;
					// [RL8] erase fills ffh
					if (run_r == OP_ERASE) begin
						for (i = 0; i < NSECT; i = i + 1) begin
							map_r[i] <= `SPM_BYTE_PROT;
						end
					end
				end else begin
					tmr_r <= tmr_r - 32'h1;
				end
			end
			// [RL10] [RL16] commit ANDs buffer 1
			if (run_r == OP_PROG && !busy_commit_done_r) begin
				map_r[commit_idx_r] <= map_r[commit_idx_r] & rd_byte;
			end
			if (cs_n) begin
				state_r <= ST_CMD;
				bit_r <= 3'h0;
				hdr_r <= 3'h0;
				idx_r <= {AW{1'b0}};
				pend_r <= OP_NONE;
				// prot_en is not consulted, so sectors unprotect in place
				// [RL6] [RL15] [RL21] [RL23] deselect starts cycle
				if (cs_rise && pend_r != OP_NONE && !busy && wp_n) begin
					run_r <= pend_r;
					tmr_r <= (pend_r == OP_ERASE) ? ERASE_CYC : PROG_CYC;
				end
			end else if (sck_rise) begin
				// [RL22] msb first, rising edge
				sh_r <= byte_in;
				bit_r <= bit_r + 3'h1;
				if (byte_done) begin
					case (state_r)
						ST_CMD: begin
							hdr_r <= hdr_r + 3'h1;
							pend_r <= OP_NONE;
							if (hdr_r == 3'h0) begin
								b0_r <= byte_in;
								// [RL17] read opcode
								if (byte_in == `SPM_OP_READ) begin
									state_r <= ST_RDUMMY;
								end
							end else if (hdr_r == 3'h1) begin
								b1_r <= byte_in;
							end else if (hdr_r == 3'h2) begin
								b2_r <= byte_in;
							end else begin
								state_r <= ST_IGNORE;
								// [RL6] erase opcode
								if (pfx_ok && byte_in == `SPM_OP_ERASE) begin
									pend_r <= OP_ERASE;
								end
								// [RL10] program opcode
								if (pfx_ok && byte_in == `SPM_OP_PROGRAM) begin
									state_r <= ST_PDATA;
								end
							end
						end
						ST_PDATA: begin
							// [RL12] [RL16] [RL23] wrapping buffer index
							buf1_wr_out <= ~busy;
							buf1_addr_out <= idx_r;
							buf1_data_out <= byte_in;
							idx_r <= idx_r + {{(AW-1){1'b0}}, 1'b1};
							pend_r <= OP_PROG;
						end
						ST_RDUMMY: begin
							// [RL17] three dummy bytes
							hdr_r <= hdr_r + 3'h1;
							if (hdr_r == `SPM_READ_HDR_BYTES - 1) begin
								state_r <= ST_ROUT;
							end
						end
						ST_ROUT: begin
							idx_r <= idx_r + {{(AW-1){1'b0}}, 1'b1};
						end
						default: begin
							state_r <= ST_IGNORE;
						end
					endcase
				end
			end
		end
	end

	// commit walker: one byte per cycle from buffer 1
	// the program cycle must last at least NSECT+1 clocks or bytes are lost
	// [RL10] [RL16] walk buffer into map
	always @(posedge clock_in) begin
		if (rst_in) begin
			commit_idx_r <= {AW{1'b0}};
			busy_commit_done_r <= 1'b1;
			commit_start_r <= 1'b0;
		end else if (run_r == OP_PROG) begin
			commit_start_r <= 1'b1;
			if (!commit_start_r) begin
				busy_commit_done_r <= 1'b0;
				commit_idx_r <= {AW{1'b0}};
			end else if (!busy_commit_done_r) begin
				commit_idx_r <= commit_idx_r + {{(AW-1){1'b0}}, 1'b1};
				if (commit_idx_r == NSECT - 1) begin
					busy_commit_done_r <= 1'b1;
				end
			end
		end else begin
			commit_start_r <= 1'b0;
			busy_commit_done_r <= 1'b1;
		end
	end

	wire [AW-1:0] mem_rd_addr = commit_start_r ?
		commit_idx_r + {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
	// buffer 1 holds program data before commit
	spm_map_mem #(.AW(AW), .DW(8)) u_buf1 (
		.clock_in(clock_in),
		.wr_en_in(buf1_wr_out),
		.wr_addr_in(buf1_addr_out),
		.wr_data_in(buf1_data_out),
		.rd_addr_in(mem_rd_addr),
		.rd_data_out(rd_byte)
	);

	// read path shifts on falling edge; released on deselect
	// [RL17] [RL19] shift out, release
	always @(posedge clock_in) begin
		if (rst_in) begin
			so_out <= 1'b0;
			so_oe_n_out <= 1'b1;
			out_sh_r <= 8'h00;
		end else if (cs_n) begin
			so_oe_n_out <= 1'b1;
		end else if (state_r == ST_ROUT && sck_fall) begin
			so_oe_n_out <= 1'b0;
			if (bit_r == 3'h0) begin
				so_out <= map_r[idx_r][7];
				out_sh_r <= {map_r[idx_r][6:0], 1'b0};
			end else begin
				so_out <= out_sh_r[7];
				out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
		end
	end

	// [RL2] [RL3] per-sector decode
	wire [7:0] sel = map_r[sector_in];
	wire sub_prot = subsector_b_in ?
		(sel[`SPM_SUB_B_HI:`SPM_SUB_B_LO] == 2'h3) :
		(sel[`SPM_SUB_A_HI:`SPM_SUB_A_LO] == 2'h3);
	assign sector_protected_out = (sector_in == {AW{1'b0}}) ? sub_prot :
		(sel == `SPM_BYTE_PROT);
	// [RL9] array writes refused
	assign array_write_ok_out = ~(prot_en_in & sector_protected_out);
endmodule

// ---- spm_map_props.sv ----
module spm_map_props #(
	parameter int ERASE_CYC = 40,
	parameter int PROG_CYC = 20
) (
	input wire clock_in,
	input wire rst_in,
	input wire cs_n_in,
	input wire sck_in,
	input wire si_in,
	input wire wp_n_in,
	input wire prot_en_in,
	input wire [3:0] sector_in,
	input wire subsector_b_in,
	input wire so_out,
	input wire so_oe_n_out,
	input wire ready_out,
	input wire sector_protected_out,
	input wire array_write_ok_out,
	input wire buf1_wr_out,
	input wire [3:0] buf1_addr_out,
	input wire [7:0] buf1_data_out
);
	// slack covers the pin synchronisers and start delay
	localparam int MAXB = ERASE_CYC + PROG_CYC + 8;
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (rst_in);
	a_rst_idle: assert property ($fell(rst_in) |-> ready_out)
		else $error("not ready after reset");
	a_oe_idle: assert property (cs_n_in [*8] |-> so_oe_n_out)
		else $error("so driven while deselected");
	a_busy_min: assert property ($fell(ready_out) |-> !ready_out [*8])
		else $error("busy too short");
	a_busy_max: assert property ($fell(ready_out) |-> ##[1:MAXB] ready_out)
		else $error("busy too long");
	a_start_desel: assert property ($fell(ready_out) |->
		cs_n_in && $past(cs_n_in, 2)) else $error("cycle began while selected");
	a_wp_blocks: assert property (!wp_n_in [*6] |-> !$fell(ready_out))
		else $error("map cycle under write protect");
	a_prot_array: assert property (prot_en_in && sector_protected_out
		|-> !array_write_ok_out) else $error("protected sector writable");
	a_buf_pulse: assert property (buf1_wr_out |=> !buf1_wr_out)
		else $error("buffer write not a pulse");
	cover property ($fell(ready_out));
	cover property ($fell(so_oe_n_out));
	cover property (buf1_wr_out);
endmodule

bind spm_map_cmd spm_map_props #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC))
	u_props (
	.clock_in(clock_in),
	.rst_in(rst_in),
	.cs_n_in(cs_n_in),
	.sck_in(sck_in),
	.si_in(si_in),
	.wp_n_in(wp_n_in),
	.prot_en_in(prot_en_in),
	.sector_in(sector_in),
	.subsector_b_in(subsector_b_in),
	.so_out(so_out),
	.so_oe_n_out(so_oe_n_out),
	.ready_out(ready_out),
	.sector_protected_out(sector_protected_out),
	.array_write_ok_out(array_write_ok_out),
	.buf1_wr_out(buf1_wr_out),
	.buf1_addr_out(buf1_addr_out),
	.buf1_data_out(buf1_data_out)
	);

// ---- spm_host.sv ----
module spm_host (
	output logic cs_n_out,
	output logic sck_out,
	output logic si_out,
	input wire so_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n_out = 1;
		sck_out = 0;
		si_out = 0;
	end
	// callers start on a clock edge; the 1 ns step keeps link edges off it
	task sel;
		#1;
		cs_n_out = 0;
		#62.5;
	endtask
	// msb first, mode 0, clock still outside frames
	task xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si_out = tx[i];
			#62.5 sck_out = 1;
			rx[i] = so_in;
			#62.5 sck_out = 0;
		end
	endtask
	// deselect only on byte bounds; stale data line inverted
	task desel;
		#62.5 cs_n_out = 1;
		si_out = ~si_out;
	endtask
endmodule

// ---- tb_top.sv ----
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
	n_errors++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_in, rst_in, wp_n, prot_en, sub_b;
	logic [3:0] sector;
	logic [7:0] rx;
	logic [7:0] mp [16];
	wire cs_n, sck, si, so, so_oe_n, ready, sprot, awok, b_wr, so_line;
	wire [3:0] b_addr;
	wire [7:0] b_data;
	int n_errors = 0;
	int tests_run = 0;
	assign so_line = so_oe_n ? 1'bz : so;
	spm_host host(.cs_n_out(cs_n), .sck_out(sck), .si_out(si), .so_in(so_line));
	spm_map_cmd #(.ERASE_CYC(40), .PROG_CYC(20)) uut(.clock_in(clock_in),
		.rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
		.wp_n_in(wp_n), .prot_en_in(prot_en), .sector_in(sector),
		.subsector_b_in(sub_b), .so_out(so), .so_oe_n_out(so_oe_n),
		.ready_out(ready), .sector_protected_out(sprot),
		.array_write_ok_out(awok), .buf1_wr_out(b_wr),
		.buf1_addr_out(b_addr), .buf1_data_out(b_data));
	initial begin
		clock_in = 0;
		forever #5 clock_in = ~clock_in;
	end
	task print_verdict;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task cmd(input logic [7:0] op);
		@(posedge clock_in);
		host.sel;
		host.xfer(8'h3d, rx);
		host.xfer(8'h2a, rx);
		host.xfer(8'h7f, rx);
		host.xfer(op, rx);
	endtask
	task go(input logic busy);
		logic seen;
		int i;
		host.desel;
		seen = 0;
		i = 0;
		repeat (20) begin
			@(posedge clock_in);
			#1;
			if (ready === 1'b0) seen = 1;
		end
		`CHK("busy", busy, seen)
		while (ready !== 1'b1 && i < 100) begin
			@(posedge clock_in);
			#1;
			i++;
		end
		`CHK("ready", 1'b1, ready)
	endtask
	task rd_map;
		@(posedge clock_in);
		host.sel;
		host.xfer(8'h32, rx);
		repeat (3) host.xfer(8'h00, rx);
		for (int k = 0; k < 16; k++) host.xfer(8'h00, mp[k]);
		host.desel;
		repeat (10) @(posedge clock_in);
		`CHK("oe_n", 1'b1, so_oe_n)
	endtask
	task q(input logic [3:0] s, input logic b, input logic ex);
		@(posedge clock_in) #1 sector = s;
		sub_b = b;
		#1 `CHK("prot", ex, sprot)
	endtask
	task t_factory;
		rd_map;
		for (int k = 0; k < 16; k++) `CHK("fmap", k < 8 ? 8'h00 : 8'hff, mp[k])
	endtask
	task t_erase;
		prot_en = 1;
		cmd(8'hcf);
		go(1'b1);
		rd_map;
		for (int k = 0; k < 16; k++) `CHK("emap", 8'hff, mp[k])
		q(4'h5, 1'b0, 1'b1);
		`CHK("awok", 1'b0, awok)
	endtask
	// erased first, valid codes; 17th byte wraps
	task t_prog;
		cmd(8'hfc);
		for (int k = 0; k < 17; k++)
			host.xfer(k == 16 ? 8'h3f : (k[0] || k == 0 ? 8'hff : 8'h00), rx);
		go(1'b1);
		`CHK("buf_addr", 4'h0, b_addr)
		`CHK("buf_data", 8'h3f, b_data)
		rd_map;
		`CHK("pmap0", 8'h3f, mp[0])
		for (int k = 1; k < 16; k++) `CHK("pmap", k[0] ? 8'hff : 8'h00, mp[k])
		q(4'h0, 1'b0, 1'b0);
		q(4'h0, 1'b1, 1'b1);
		q(4'h2, 1'b0, 1'b0);
		`CHK("awok_unprot", 1'b1, awok)
		q(4'h3, 1'b0, 1'b1);
	endtask
	task t_wp;
		wp_n = 0;
		repeat (10) @(posedge clock_in);
		cmd(8'hcf);
		go(1'b0);
		rd_map;
		`CHK("wmap0", 8'h3f, mp[0])
		wp_n = 1;
	endtask
	initial begin
		rst_in = 1;
		wp_n = 1;
		prot_en = 0;
		sector = 0;
		sub_b = 0;
		repeat (6) @(posedge clock_in);
		#1 rst_in = 0;
		repeat (5) @(posedge clock_in);
		// one map erase and one program per run
		t_factory;
		t_erase;
		t_prog;
		t_wp;
		print_verdict;
	end
	// runs near 112 us; limit well above
	initial begin
		#400000;
		n_errors++;
		print_verdict;
	end
endmodule
